// ===== rtl/plink_map.svh
// Purpose: Constants for the PHY-Link interface, both ends
// Assumes: 25 MHz design clock; link traffic runs on clk
// Notes: Overview of operation in the list below
//
// Overview of operation
// [R1] Device drives control lines for status/receive
// [R2] Device grants bus to link for transmit
// [R3] Status data uses data lines 0 and 1
// [R4] Data width 2/4/8 lines by speed
// [R5] Data line 0 is the word MSB
// [R6] Link sends requests serially on request line
// [R7] Requests: register write/read, transmit, acceleration
// [R8] Device outputs system clock from its PLL
// [R9] All link signals synchronous to system clock
// [R10] Power status low resets and disables interface
// [R11] Link drives power status level or pulses
// [R12] Link inactive when power low or flag zero
// [R13] Link-on pulse train between 4 and 8 MHz
// [R14] Isolation select high direct, low isolated
// [R15] Lock indicator high while PLL locked
// [R16] Link-on static while link active
`ifndef PLINK_MAP_SVH
`define PLINK_MAP_SVH
// Control line codes
`define PLINK_CTL_IDLE 2'h0
`define PLINK_CTL_STATUS 2'h1
`define PLINK_CTL_RECEIVE 2'h2
`define PLINK_CTL_GRANT 2'h3
`define PLINK_CTL_HOLD 2'h1
`define PLINK_CTL_TRANSMIT 2'h2
// Request frame: start bit, 3 type bits, 8 payload bits
`define PLINK_REQ_LEN 4'hc
`define PLINK_REQ_TYPE_W 3
`define PLINK_REQ_WRITE 3'h1
`define PLINK_REQ_READ 3'h2
`define PLINK_REQ_XMIT 3'h3
`define PLINK_REQ_ACCEL 3'h4
// Speed codes
`define PLINK_SPD_100 2'h0
`define PLINK_SPD_200 2'h1
`define PLINK_SPD_400 2'h2
// Link-on pulse: 25 MHz / 4 = 6.25 MHz, inside 4 to 8 MHz
`define PLINK_LINK_ON_INDICATION_MHZ_X100 625
`define PLINK_CLK_MHZ_X100 2500
`define PLINK_LINK_ON_INDICATION_DIV (`PLINK_CLK_MHZ_X100 / `PLINK_LINK_ON_INDICATION_MHZ_X100)
`define PLINK_LINK_ON_INDICATION_HALF 2'h1
// Power status pulse timeout in isolated mode (cycles)
`define PLINK_LPS_TIMEOUT 6'h3f
// Reset value of the active flag
`define PLINK_ACTIVE_RST 1'h1
`endif

// ===== rtl/plink_pkg.sv
// Purpose: Types shared by both ends
// Assumes: plink_map.svh holds the numbers
// Notes: none
package plink_pkg;
	// Device state of the interface
	typedef enum logic [2:0] {PLINK_IDLE, PLINK_STATUS, PLINK_RECV, PLINK_GRANT, PLINK_XMIT} plink_state_type;
	// Request receive state
	typedef enum logic [1:0] {PLINK_RQ_WAIT, PLINK_RQ_SHIFT} plink_req_type;
endpackage

// ===== rtl/plink_if.sv
// Purpose: Wires between the device end and the link end
// Assumes: two-way lines resolved from enables here
// Notes: device wins on overlap never happens by protocol
`timescale 1ns/1ps
interface plink_if;
	logic sys_clk; // System clock from device
	logic link_request_line; // Serial requests
	logic link_power_status; // Power status from link
	logic link_on_indication; // Link-on to link
	logic [1:0] dev_ctl_o; // Device control drive
	logic dev_ctl_oe; // Device drives control
	logic [7:0] dev_data_o; // Device data drive
	logic dev_data_oe; // Device drives data
	logic [1:0] lnk_ctl_o; // Link control drive
	logic lnk_ctl_oe; // Link drives control
	logic [7:0] lnk_data_o; // Link data drive
	logic lnk_data_oe; // Link drives data
	logic [1:0] ctl; // Resolved control lines
	logic [7:0] data; // Resolved data lines
	// Resolve shared lines; bus hold keeps zero when nobody drives
	assign ctl = dev_ctl_oe ? dev_ctl_o : (lnk_ctl_oe ? lnk_ctl_o : 2'h0);
	assign data = dev_data_oe ? dev_data_o : (lnk_data_oe ? lnk_data_o : 8'h00);
	modport device (output sys_clk, input link_request_line, input link_power_status,
		output link_on_indication, output dev_ctl_o, output dev_ctl_oe, output dev_data_o,
		output dev_data_oe, input ctl, input data);
	modport link (input sys_clk, output link_request_line, output link_power_status,
		input link_on_indication, output lnk_ctl_o, output lnk_ctl_oe, output lnk_data_o,
		output lnk_data_oe, input ctl, input data);
endinterface

// ===== rtl/plink_phy.sv
// Purpose: Device end of the PHY-Link interface
// Assumes: clk is the PLL output, pll_locked from the PLL
// Notes: link-facing logic runs on clk, which is driven out
`timescale 1ns/1ps
`include "plink_map.svh"
module plink_phy
	import plink_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	plink_if.device lnk,
	input wire logic pll_locked,
	input wire logic isolation_select,
	input wire logic link_active_flag,
	input wire logic [1:0] speed,
	input wire logic status_req,
	input wire logic [7:0] status_data,
	input wire logic recv_req,
	input wire logic [7:0] recv_data,
	input wire logic recv_last,
	output logic req_valid,
	output logic [2:0] req_type,
	output logic [7:0] req_payload,
	output logic [7:0] xmit_data,
	output logic xmit_valid,
	output logic busy,
	output logic pll_lock_indicator,
	output logic direct_mode,
	output logic iface_enabled
);
	////////////////////////////////////////////////////////////////////////
	// Helpers
	// Data lanes used at a speed, data line 0 as MSB
	function automatic logic [7:0] lane_mask(input logic [1:0] spd);
		case (spd)
			`PLINK_SPD_100: lane_mask = 8'hc0; // [R4]
			`PLINK_SPD_200: lane_mask = 8'hf0; // [R4]
			default: lane_mask = 8'hff; // [R4]
		endcase
	endfunction
	// Lines per beat
	function automatic logic [3:0] lane_count(input logic [1:0] spd);
		case (spd)
			`PLINK_SPD_100: lane_count = 4'h2;
			`PLINK_SPD_200: lane_count = 4'h4;
			default: lane_count = 4'h8;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic [1:0] lps_sync_q; // Power status sync
	logic [1:0] iso_sync_q; // Isolation select sync
	logic [1:0] lock_sync_q; // Lock sync
	// Two flops on the power status, isolation select and lock inputs
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			lps_sync_q <= 2'h0;
			iso_sync_q <= 2'h0;
			lock_sync_q <= 2'h0;
		end
		else
		begin
			lps_sync_q <= {lps_sync_q[0], lnk.link_power_status};
			iso_sync_q <= {iso_sync_q[0], isolation_select};
			lock_sync_q <= {lock_sync_q[0], pll_locked};
		end
	end
	assign lnk.sys_clk = clk; // [R8] [R9]
	assign pll_lock_indicator = lock_sync_q[1]; // [R15]
	assign direct_mode = iso_sync_q[1]; // [R14]
	////////////////////////////////////////////////////////////////////////
	// Power status: level in direct mode, pulses in isolated mode
	logic [5:0] lps_timer_q; // Cycles since last pulse
	logic lps_prev_q; // Previous synced level
	logic lps_on; // Power status seen as asserted
	// Pulse watchdog for isolated mode
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			lps_timer_q <= `PLINK_LPS_TIMEOUT;
			lps_prev_q <= 1'b0;
		end
		else
		begin
			lps_prev_q <= lps_sync_q[1];
			if (lps_sync_q[1] && !lps_prev_q)
				lps_timer_q <= 6'h00;
			else if (lps_timer_q != `PLINK_LPS_TIMEOUT)
				lps_timer_q <= lps_timer_q + 6'h01;
		end
	end
	assign lps_on = direct_mode ? lps_sync_q[1] : (lps_timer_q != `PLINK_LPS_TIMEOUT); // [R14]
	assign iface_enabled = lps_on; // [R10]
	////////////////////////////////////////////////////////////////////////
	// Link-on pulse train while the link is inactive
	logic [1:0] link_on_indication_cnt_q; // Divider
	logic link_on_indication_q; // Pulse output
	// Toggle every half period when inactive, else hold low
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			link_on_indication_cnt_q <= 2'h0;
			link_on_indication_q <= 1'b0;
		end
		else if (lps_on && link_active_flag) // [R12]
		begin
			link_on_indication_cnt_q <= 2'h0;
			link_on_indication_q <= 1'b0; // [R16]
		end
		else if (link_on_indication_cnt_q == `PLINK_LINK_ON_INDICATION_HALF)
		begin
			link_on_indication_cnt_q <= 2'h0;
			link_on_indication_q <= ~link_on_indication_q; // [R13]
		end
		else
			link_on_indication_cnt_q <= link_on_indication_cnt_q + 2'h1;
	end
	assign lnk.link_on_indication = link_on_indication_q;
	////////////////////////////////////////////////////////////////////////
	// Serial request receiver
	plink_req_type rq_state_q; // Receiver state
	logic [3:0] rq_cnt_q; // Bits received
	logic [10:0] rq_shift_q; // Type and payload, MSB first
	// Detect start, shift in type and payload
	always_ff @(posedge clk)
	begin
		if (!nrst || !lps_on) // [R10]
		begin
			rq_state_q <= PLINK_RQ_WAIT;
			rq_cnt_q <= 4'h0;
			rq_shift_q <= 11'h000;
			req_valid <= 1'b0;
			req_type <= 3'h0;
			req_payload <= 8'h00;
		end
		else
		begin
			req_valid <= 1'b0;
			case (rq_state_q)
				PLINK_RQ_WAIT:
				begin
					if (lnk.link_request_line) // [R6]
					begin
						rq_state_q <= PLINK_RQ_SHIFT;
						rq_cnt_q <= 4'h1;
					end
				end
				PLINK_RQ_SHIFT:
				begin
					rq_shift_q <= {rq_shift_q[9:0], lnk.link_request_line};
					rq_cnt_q <= rq_cnt_q + 4'h1;
					if (rq_cnt_q == `PLINK_REQ_LEN - 4'h1)
					begin
						rq_state_q <= PLINK_RQ_WAIT;
						req_valid <= 1'b1; // [R7]
						req_type <= rq_shift_q[9:7];
						req_payload <= {rq_shift_q[6:0], lnk.link_request_line};
					end
				end
				default: rq_state_q <= PLINK_RQ_WAIT;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Interface state machine
	plink_state_type st_q; // Interface state
	logic [7:0] sh_q; // Outgoing word shifter
	logic [3:0] bits_q; // Bits left in word
	logic xmit_pend_q; // Transmit requested
	// Status, receive, grant and transmit sequencing
	always_ff @(posedge clk)
	begin
		if (!nrst || !lps_on) // [R10]
		begin
			st_q <= PLINK_IDLE;
			sh_q <= 8'h00;
			bits_q <= 4'h0;
			xmit_pend_q <= 1'b0;
			xmit_data <= 8'h00;
			xmit_valid <= 1'b0;
		end
		else
		begin
			xmit_valid <= 1'b0;
			case (st_q)
				PLINK_IDLE:
				begin
					if (recv_req)
					begin
						st_q <= PLINK_RECV; // [R1]
						sh_q <= recv_data;
						bits_q <= lane_count(speed);
					end
					else if (status_req)
					begin
						st_q <= PLINK_STATUS; // [R1]
						sh_q <= status_data;
						bits_q <= 4'h8;
					end
					else if (xmit_pend_q)
					begin
						st_q <= PLINK_GRANT; // [R2]
						xmit_pend_q <= 1'b0;
					end
				end
				PLINK_STATUS:
				begin
					sh_q <= {sh_q[5:0], 2'h0}; // [R3]
					bits_q <= bits_q - 4'h2;
					if (bits_q == 4'h2)
						st_q <= PLINK_IDLE;
				end
				PLINK_RECV:
				begin
					if (recv_last)
						st_q <= PLINK_IDLE;
					else
						sh_q <= recv_data;
				end
				PLINK_GRANT:
					st_q <= PLINK_XMIT; // [R2]
				PLINK_XMIT:
				begin
					if (lnk.ctl == `PLINK_CTL_TRANSMIT)
					begin
						xmit_data <= lnk.data & lane_mask(speed); // [R4] [R5]
						xmit_valid <= 1'b1;
					end
					else if (lnk.ctl == `PLINK_CTL_IDLE)
						st_q <= PLINK_IDLE; // [R2]
				end
				default: st_q <= PLINK_IDLE;
			endcase
			if (req_valid && req_type == `PLINK_REQ_XMIT) // Set wins over the grant clear
				xmit_pend_q <= 1'b1; // [R7]
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Line drive
	// Control and data drive per state
	always_comb
	begin
		lnk.dev_ctl_o = `PLINK_CTL_IDLE;
		lnk.dev_ctl_oe = lps_on;
		lnk.dev_data_o = 8'h00;
		lnk.dev_data_oe = lps_on;
		case (st_q)
			PLINK_STATUS:
			begin
				lnk.dev_ctl_o = `PLINK_CTL_STATUS; // [R1]
				lnk.dev_data_o = {sh_q[7:6], 6'h00}; // [R3] [R5]
			end
			PLINK_RECV:
			begin
				lnk.dev_ctl_o = `PLINK_CTL_RECEIVE; // [R1]
				lnk.dev_data_o = sh_q & lane_mask(speed); // [R4] [R5]
			end
			PLINK_GRANT:
				lnk.dev_ctl_o = `PLINK_CTL_GRANT; // [R2]
			PLINK_XMIT:
			begin
				lnk.dev_ctl_oe = 1'b0; // [R2]
				lnk.dev_data_oe = 1'b0;
			end
			default: ;
		endcase
	end
	assign busy = (st_q != PLINK_IDLE);
endmodule

// ===== rtl/plink_link.sv
// Purpose: Link-controller end of the PHY-Link interface
// Assumes: clk is the system clock taken from the device
// Notes: one request in flight at a time
`timescale 1ns/1ps
`include "plink_map.svh"
module plink_link
	import plink_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	plink_if.link lnk,
	input wire logic power_on,
	input wire logic isolated_mode,
	input wire logic req_start,
	input wire logic [2:0] req_kind,
	input wire logic [7:0] req_arg,
	output logic req_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic tx_take,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic status_valid,
	output logic link_on_seen
);
	////////////////////////////////////////////////////////////////////////
	// Power status drive: level or pulse train
	logic [1:0] lps_div_q; // Pulse divider
	// Pulse every fourth cycle in isolated mode
	always_ff @(posedge clk)
	begin
		if (!nrst)
			lps_div_q <= 2'h0;
		else
			lps_div_q <= lps_div_q + 2'h1;
	end
	assign lnk.link_power_status = power_on && (!isolated_mode || lps_div_q == 2'h0); // [R11]
	assign link_on_seen = lnk.link_on_indication;
	////////////////////////////////////////////////////////////////////////
	// Serial request sender
	logic [11:0] rq_sh_q; // Start, type, payload
	logic [3:0] rq_left_q; // Bits left
	// Shift the request out MSB first
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			rq_sh_q <= 12'h000;
			rq_left_q <= 4'h0;
		end
		else if (req_start && req_ready)
		begin
			rq_sh_q <= {1'b1, req_kind, req_arg}; // [R6] [R7]
			rq_left_q <= `PLINK_REQ_LEN;
		end
		else if (rq_left_q != 4'h0)
		begin
			rq_sh_q <= {rq_sh_q[10:0], 1'b0};
			rq_left_q <= rq_left_q - 4'h1;
		end
	end
	assign req_ready = (rq_left_q == 4'h0);
	assign lnk.link_request_line = (rq_left_q != 4'h0) && rq_sh_q[11]; // [R6] [R9]
	////////////////////////////////////////////////////////////////////////
	// Receive, status and transmit
	logic owns_q; // Link owns the lines
	logic done_q; // Last word sent, release next
	// Take the bus on grant, hand it back after the last word
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			owns_q <= 1'b0;
			done_q <= 1'b0;
			rx_data <= 8'h00;
			rx_valid <= 1'b0;
			status_valid <= 1'b0;
		end
		else
		begin
			rx_valid <= 1'b0;
			status_valid <= 1'b0;
			if (!owns_q && lnk.ctl == `PLINK_CTL_GRANT)
			begin
				owns_q <= 1'b1; // [R2]
				done_q <= 1'b0;
			end
			else if (owns_q && done_q)
				owns_q <= 1'b0; // [R2]
			else if (owns_q && tx_last)
				done_q <= 1'b1;
			if (!owns_q && lnk.ctl == `PLINK_CTL_RECEIVE)
			begin
				rx_data <= lnk.data; // [R5]
				rx_valid <= 1'b1;
			end
			if (!owns_q && lnk.ctl == `PLINK_CTL_STATUS)
			begin
				rx_data <= {rx_data[5:0], lnk.data[7:6]}; // [R3]
				status_valid <= 1'b1;
			end
		end
	end
	assign tx_take = owns_q && !done_q;
	assign lnk.lnk_ctl_oe = owns_q; // [R2]
	assign lnk.lnk_data_oe = owns_q;
	assign lnk.lnk_ctl_o = tx_take ? `PLINK_CTL_TRANSMIT : `PLINK_CTL_IDLE;
	assign lnk.lnk_data_o = tx_take ? tx_data : 8'h00; // [R4] [R5]
endmodule

// ===== testbench/plink_properties.sv
// Purpose: Wire checks between the device end and the link end
// Assumes: one clock domain, nrst synchronous active low
// Notes: inputs are the interface signals only
`timescale 1ns/1ps
`include "plink_map.svh"
module plink_properties
	import plink_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic link_on_indication,
	input wire logic [1:0] dev_ctl_o,
	input wire logic dev_ctl_oe,
	input wire logic dev_data_oe,
	input wire logic [1:0] lnk_ctl_o,
	input wire logic lnk_ctl_oe,
	input wire logic lnk_data_oe
);
	logic grant; // Device hands the bus over
	logic stat; // Device sends a status beat
	logic xmit; // Link sends a packet beat
	assign grant = dev_ctl_oe && dev_ctl_o == `PLINK_CTL_GRANT;
	assign stat = dev_ctl_oe && dev_ctl_o == `PLINK_CTL_STATUS;
	assign xmit = lnk_ctl_oe && lnk_ctl_o == `PLINK_CTL_TRANSMIT;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////
	chk_ctl_one_driver: assert property (!(dev_ctl_oe && lnk_ctl_oe))
		else $error("both ends drive control");
	chk_data_one_driver: assert property (!(dev_data_oe && lnk_data_oe))
		else $error("both ends drive data");
	chk_grant_one_cycle: assert property (grant |=> !dev_ctl_oe)
		else $error("device kept control after grant");
	chk_link_takes_bus: assert property (grant |-> ##[1:3] xmit)
		else $error("no transmit after grant");
	chk_link_returns_bus: assert property (lnk_ctl_oe && lnk_ctl_o == `PLINK_CTL_IDLE |=> !lnk_ctl_oe)
		else $error("link kept the bus");
	chk_xmit_data_driven: assert property (xmit |-> lnk_data_oe)
		else $error("transmit beat without data");
	chk_status_four_beats: assert property ($rose(stat) |-> stat [*4])
		else $error("status shorter than four beats");
	chk_status_data_on: assert property (stat |-> dev_data_oe)
		else $error("status beat without data");
	chk_recv_data_on: assert property (dev_ctl_oe && dev_ctl_o == `PLINK_CTL_RECEIVE |-> dev_data_oe)
		else $error("receive beat without data");
	chk_link_on_indication_min_period: assert property ($rose(link_on_indication) |=> (!$rose(link_on_indication)) [*3])
		else $error("link-on pulses too fast");
	chk_link_on_indication_pulse_short: assert property ($rose(link_on_indication) |-> ##[1:6] !link_on_indication)
		else $error("link-on high too long");
	// Main scenarios reached
	cover_grant: cover property (grant);
	cover_status: cover property ($rose(stat));
	cover_link_on_indication: cover property ($rose(link_on_indication));
endmodule

// ===== testbench/phy_link_interface_tb.sv
// Purpose: Bench joining both ends of the interface
// Assumes: inputs driven and outputs sampled on falling edges
// Notes: outputs have settled by the falling edge
`timescale 1ns/1ps
`include "plink_map.svh"
module phy_link_interface_tb
	import plink_pkg::*;
;
	// Bench-driven inputs
	logic clk = 1'h0, nrst = 1'h0, pll_locked = 1'h1, isolation_select = 1'h1, link_active_flag = 1'h1;
	logic status_req = 1'h0, recv_req = 1'h0, recv_last = 1'h0, power_on = 1'h1, isolated_mode = 1'h0;
	logic req_start = 1'h0, tx_last = 1'h0;
	logic [1:0] speed = `PLINK_SPD_400;
	logic [2:0] req_kind = 3'h0;
	logic [7:0] status_data = 8'h00, recv_data = 8'h00, req_arg = 8'h00, tx_data = 8'h00;
	// Design outputs
	logic req_valid, xmit_valid, busy, pll_lock_indicator, direct_mode, iface_enabled;
	logic req_ready, tx_take, rx_valid, status_valid, link_on_seen;
	logic [2:0] req_type;
	logic [7:0] req_payload, xmit_data, rx_data;
	int error_cnt = 0, checked = 0;
	plink_if lnk();
	plink_phy plink_phy_inst(.clk, .nrst, .lnk, .pll_locked, .isolation_select, .link_active_flag, .speed,
		.status_req, .status_data, .recv_req, .recv_data, .recv_last, .req_valid, .req_type, .req_payload,
		.xmit_data, .xmit_valid, .busy, .pll_lock_indicator, .direct_mode, .iface_enabled);
	plink_link plink_link_inst(.clk, .nrst, .lnk, .power_on, .isolated_mode, .req_start, .req_kind, .req_arg,
		.req_ready, .tx_data, .tx_last, .tx_take, .rx_data, .rx_valid, .status_valid, .link_on_seen);
	plink_properties plink_properties_inst(.clk(clk), .nrst(nrst), .link_on_indication(lnk.link_on_indication),
		.dev_ctl_o(lnk.dev_ctl_o), .dev_ctl_oe(lnk.dev_ctl_oe), .dev_data_oe(lnk.dev_data_oe),
		.lnk_ctl_o(lnk.lnk_ctl_o), .lnk_ctl_oe(lnk.lnk_ctl_oe), .lnk_data_oe(lnk.lnk_data_oe));
	// 25 MHz clock
	always #20 clk = ~clk;
	////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic complete_run();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Compare one value
	task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// Bounded wait for a level, ends the run when it runs out
	task automatic wait_for(ref logic sig, input logic val, input int lim);
		for (int i = 0; i < lim && sig !== val; i++)
			@(negedge clk);
		if (sig !== val)
		begin
			error_cnt++;
			$display("mismatch at %0t: wait ran out", $time);
			complete_run();
		end
	endtask
	// Send one request, read its frame off the wire
	task automatic send_req(input logic [2:0] kind, input logic [7:0] arg, input bit answer);
		logic [10:0] bits;
		int n;
		bits = 11'h000;
		n = 0;
		wait_for(req_ready, 1'h1, 100);
		req_start = 1'h1;
		req_kind = kind;
		req_arg = arg;
		for (int i = 0; i < 40 && n < 12; i++)
		begin
			@(negedge clk);
			req_start = 1'h0;
			if (n > 0)
			begin
				bits = {bits[9:0], lnk.link_request_line};
				n++;
			end
			else if (lnk.link_request_line === 1'h1)
				n = 1;
		end
		check8({5'h00, bits[10:8]}, {5'h00, kind}, "wire type");
		check8(bits[7:0], arg, "wire payload");
		if (answer)
		begin
			wait_for(req_valid, 1'h1, 10);
			check8({5'h00, req_type}, {5'h00, kind}, "req type");
			check8(req_payload, arg, "req payload");
		end
	endtask
	// Status byte, four beats on the two lowest data lines
	task automatic send_status(input logic [7:0] v);
		logic [7:0] got;
		int k;
		got = 8'h00;
		k = 0;
		status_req = 1'h1;
		status_data = v;
		for (int i = 0; i < 30 && k < 4; i++)
		begin
			@(negedge clk);
			if (lnk.dev_ctl_oe === 1'h1 && lnk.ctl === `PLINK_CTL_STATUS)
			begin
				status_req = 1'h0;
				if (k == 0)
					check8({7'h00, busy}, 8'h01, "busy in status");
				got = {got[5:0], lnk.data[7:6]};
				k++;
			end
		end
		check8(got, v, "status beats");
		@(negedge clk);
		check8({7'h00, status_valid}, 8'h01, "link status beat");
		check8(rx_data, v, "link status byte");
		check8({7'h00, busy}, 8'h00, "idle after status");
	endtask
	// One received word at a given speed
	task automatic send_recv(input logic [1:0] spd, input logic [7:0] v, input logic [7:0] mask);
		logic [7:0] got;
		got = 8'h00;
		speed = spd;
		recv_req = 1'h1;
		recv_data = v;
		recv_last = 1'h1;
		for (int i = 0; i < 30; i++)
		begin
			@(negedge clk);
			if (lnk.ctl === `PLINK_CTL_RECEIVE)
				recv_req = 1'h0;
			if (rx_valid === 1'h1)
				got = rx_data;
		end
		recv_req = 1'h0;
		recv_last = 1'h0;
		check8(got, v & mask, "received word");
	endtask
	// Three-byte transmit after a grant
	task automatic send_xmit();
		logic [7:0] b [3];
		int k, t;
		bit pend;
		b = '{8'ha5, 8'h3c, 8'h81};
		k = 0;
		t = 0;
		pend = 0;
		speed = `PLINK_SPD_400;
		tx_data = b[0];
		tx_last = 1'h0;
		send_req(`PLINK_REQ_XMIT, 8'h00, 1'h0);
		for (int i = 0; i < 60 && k < 3; i++)
		begin
			@(negedge clk);
			if (pend && t < 2)
			begin
				t++;
				tx_data = b[t];
				tx_last = (t == 2);
			end
			pend = (tx_take === 1'h1);
			if (xmit_valid === 1'h1 && k < 3)
			begin
				check8(xmit_data, b[k], "xmit byte");
				k++;
			end
		end
		check8(k[7:0], 8'h03, "xmit count");
		check8({7'h00, tx_take}, 8'h00, "take released");
		tx_last = 1'h0;
		@(negedge clk);
		check8({7'h00, busy}, 8'h00, "bus returned");
	endtask
	// Rising edges of link-on over 40 cycles
	task automatic link_on_indication_rises(output int n);
		logic prev;
		n = 0;
		prev = link_on_seen;
		repeat (40)
		begin
			@(negedge clk);
			if (prev === 1'h0 && link_on_seen === 1'h1)
				n++;
			prev = link_on_seen;
		end
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		int n;
		repeat (12) @(negedge clk);
		nrst = 1'h1;
		wait_for(iface_enabled, 1'h1, 200);
		check8({7'h00, direct_mode}, 8'h01, "direct");
		check8({7'h00, pll_lock_indicator}, 8'h01, "locked");
		pll_locked = 1'h0;
		repeat (6) @(negedge clk);
		check8({7'h00, pll_lock_indicator}, 8'h00, "unlocked");
		pll_locked = 1'h1;
		link_on_indication_rises(n);
		check8(n[7:0], 8'h00, "link-on static");
		send_req(`PLINK_REQ_WRITE, 8'h5a, 1'h1);
		send_req(`PLINK_REQ_READ, 8'h81, 1'h1);
		send_req(`PLINK_REQ_ACCEL, 8'hff, 1'h1);
		send_status(8'hc6);
		send_recv(`PLINK_SPD_100, 8'hb7, 8'hc0);
		send_recv(`PLINK_SPD_200, 8'hb7, 8'hf0);
		send_recv(`PLINK_SPD_400, 8'hb7, 8'hff);
		send_xmit();
		link_active_flag = 1'h0;
		repeat (8) @(negedge clk);
		link_on_indication_rises(n);
		check8({7'h00, n >= 9 && n <= 11}, 8'h01, "link-on rate, flag");
		link_active_flag = 1'h1;
		power_on = 1'h0;
		wait_for(iface_enabled, 1'h0, 100);
		link_on_indication_rises(n);
		check8({7'h00, n >= 9 && n <= 11}, 8'h01, "link-on rate, power");
		isolation_select = 1'h0;
		isolated_mode = 1'h1;
		power_on = 1'h1;
		wait_for(iface_enabled, 1'h1, 300);
		check8({7'h00, direct_mode}, 8'h00, "isolated");
		send_req(`PLINK_REQ_READ, 8'h24, 1'h1);
		complete_run();
	end
endmodule
